// File: hdl/lbs_regs.vh
// timing constants and phase codes for the ballast start-up sequencer
`ifndef LBS_REGS_VH
`define LBS_REGS_VH
// clock period in picoseconds (200 MHz)
`define LBS_CLK_PS 5000
// times in microseconds
`define LBS_BUS_SAMPLE_US 130
`define LBS_PFC_DELAY_US 300
`define LBS_SOFT_STEP_US 650
`define LBS_IGN_STEP_US 324
// times in milliseconds
`define LBS_BUS95_MS 80
`define LBS_PREHEAT_MAX_MS 2500
`define LBS_IGN_MAX_MS 237
`define LBS_PRERUN_MS 625
// step counts
`define LBS_SOFT_STEPS 15
`define LBS_IGN_STEPS 127
// cycle counts derived from the times (exact multiples of 200 cycles per microsecond)
`define LBS_CYC_PER_US (1000000 / `LBS_CLK_PS)
`define LBS_BUS_SAMPLE_CYC (`LBS_BUS_SAMPLE_US * `LBS_CYC_PER_US)
`define LBS_PFC_DELAY_CYC (`LBS_PFC_DELAY_US * `LBS_CYC_PER_US)
`define LBS_SOFT_STEP_CYC (`LBS_SOFT_STEP_US * `LBS_CYC_PER_US)
`define LBS_IGN_STEP_CYC (`LBS_IGN_STEP_US * `LBS_CYC_PER_US)
`define LBS_BUS95_CYC (`LBS_BUS95_MS * 1000 * `LBS_CYC_PER_US)
`define LBS_PREHEAT_MAX_CYC (`LBS_PREHEAT_MAX_MS * 1000 * `LBS_CYC_PER_US)
`define LBS_IGN_MAX_CYC (`LBS_IGN_MAX_MS * 1000 * `LBS_CYC_PER_US)
`define LBS_PRERUN_CYC (`LBS_PRERUN_MS * 1000 * `LBS_CYC_PER_US)
// preheat time setting has 127 steps across the full range
`define LBS_PREHEAT_SET_STEPS 127
// frequency step index width
`define LBS_STEP_W 7
// one-hot phase codes
`define LBS_PH_UVLO 10'h001
`define LBS_PH_HYST 10'h002
`define LBS_PH_BUSCHK 10'h004
`define LBS_PH_START 10'h008
`define LBS_PH_SOFT 10'h010
`define LBS_PH_PREHEAT 10'h020
`define LBS_PH_IGN 10'h040
`define LBS_PH_PRERUN 10'h080
`define LBS_PH_RUN 10'h100
`define LBS_PH_FAULT 10'h200
`endif

// File: hdl/lbs_timer.v
// down-counting timer reloaded from load_val whenever load is high on a cycle with clk_en set
`timescale 1ns/1ps
module lbs_timer
#(
	parameter W = 32
)
(
	input wire clk_sys,
	input wire rst_n,
	input wire clk_en,
	input wire load,
	input wire [W-1:0] load_val,
	output reg expired_reg
);
	reg [W-1:0] cnt_reg;
	// ****************************************
	// count down, flag when zero reached
	// ****************************************
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= {W{1'b0}};
			expired_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (load)
			begin
				cnt_reg <= load_val;
				expired_reg <= 1'b0;
			end
			else if (cnt_reg != {W{1'b0}})
			begin
				cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
				expired_reg <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
			end
			else
			begin
				expired_reg <= 1'b1;
			end
		end
	end
endmodule // lbs_timer

// File: hdl/lbs_sequencer.v
// start-up phase sequencer for a lamp ballast controller
// Functional notes
// - inactive below lockout; above starts filament detection
// - sample bus band for 130 us
// - bus ok and filaments: start 135 kHz
// - bus must reach 95% within 80 ms
// - soft start: 15 steps of 650 us
// - preheat hold, programmable up to 2500 ms
// - ignition: 127 steps of 324 us
// - slope and 0.8 V halt descent
// - ignition limited 237 ms, else latched fault
// - 625 ms pre-run, then run monitoring
// - run mode monitors listed fault conditions
// - restart sense over 1.6 V flags open low filament
// - no lamp-sense current boosts restart source current
// - defective filament keeps device monitoring, no power-up
// - bus out of band: wait lockout, no power-up
// - pfc gate follows inverter by 300 us
`timescale 1ns/1ps
`include "lbs_regs.vh"
module lbs_sequencer
#(
	parameter BUS95_CYC = `LBS_BUS95_CYC,
	parameter PREHEAT_MAX_CYC = `LBS_PREHEAT_MAX_CYC,
	parameter IGN_MAX_CYC = `LBS_IGN_MAX_CYC,
	parameter PRERUN_CYC = `LBS_PRERUN_CYC,
	parameter BUS_SAMPLE_CYC = `LBS_BUS_SAMPLE_CYC,
	parameter PFC_DELAY_CYC = `LBS_PFC_DELAY_CYC,
	parameter SOFT_STEP_CYC = `LBS_SOFT_STEP_CYC,
	parameter IGN_STEP_CYC = `LBS_IGN_STEP_CYC
)
(
	input wire clk_sys,
	input wire rst_n,
	input wire clk_en,
	input wire vcc_above_lockout,
	input wire vcc_above_start,
	input wire bus_below_low,
	input wire bus_above_high,
	input wire bus_above_95,
	input wire restart_above_thr,
	input wire lamp_voltage_sense_a,
	input wire lamp_voltage_sense_b,
	input wire low_side_current_sense,
	input wire current_slope_hit,
	input wire [6:0] preheat_time_set,
	input wire bus_overvoltage,
	input wire bus_undervoltage,
	input wire open_loop,
	input wire pfc_overcurrent,
	input wire inv_overcurrent,
	input wire lamp_overvoltage_fault,
	input wire rectifier_effect_fault,
	input wire capacitive_load,
	output reg [9:0] phase_reg,
	output reg [1:0] freq_mode_reg,
	output reg [6:0] freq_step_reg,
	output reg inv_gate_en_reg,
	output reg pfc_gate_en_reg,
	output reg detect_active_reg,
	output reg low_fil_open_reg,
	output reg high_fil_open_reg,
	output reg restart_boost_reg,
	output reg monitor_en_reg,
	output reg run_fault_reg,
	output reg latched_fault_reg
);
	// frequency mode codes: start, soft ramp, preheat, ignition ramp
	localparam [1:0] FM_START = 2'h0;
	localparam [1:0] FM_SOFT = 2'h1;
	localparam [1:0] FM_PREHEAT = 2'h2;
	localparam [1:0] FM_IGN = 2'h3;
	// preheat cycles per setting step (setting 127 gives full duration)
	localparam [31:0] PH_STEP_CYC = PREHEAT_MAX_CYC / `LBS_PREHEAT_SET_STEPS;
	// last index of each ramp, cut to the width of the step register
	localparam [31:0] SOFT_LAST = `LBS_SOFT_STEPS - 1;
	localparam [31:0] IGN_LAST = `LBS_IGN_STEPS;

	reg [9:0] phase_next;
	reg load_phase;
	reg [31:0] phase_load_val;
	reg load_step;
	reg [31:0] step_load_val;
	reg load_pfc;
	reg halted_reg;
	wire phase_exp;
	wire step_exp;
	wire pfc_exp;
	wire fil_ok;
	wire lamp_sense_ok;
	wire bus_in_band;
	wire run_err;
	wire [31:0] preheat_cyc;

	assign lamp_sense_ok = lamp_voltage_sense_a | lamp_voltage_sense_b;
	// high filament open mirrored onto restart threshold
	assign fil_ok = !restart_above_thr && lamp_sense_ok;
	assign bus_in_band = !bus_below_low && !bus_above_high;
	assign preheat_cyc = PH_STEP_CYC * {25'h0000000, preheat_time_set};
	assign run_err = bus_overvoltage | bus_undervoltage | open_loop | pfc_overcurrent | inv_overcurrent
		| lamp_overvoltage_fault | rectifier_effect_fault | capacitive_load;

	// ****************************************
	// shared timebase instances
	// ****************************************
	// phase duration timer
	lbs_timer #(.W(32)) u_phase_tmr
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.load(load_phase),
		.load_val(phase_load_val),
		.expired_reg(phase_exp)
	);
	// frequency step interval timer
	lbs_timer #(.W(32)) u_step_tmr
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.load(load_step),
		.load_val(step_load_val),
		.expired_reg(step_exp)
	);
	// pfc start delay timer
	lbs_timer #(.W(32)) u_pfc_tmr
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.load(load_pfc),
		.load_val(PFC_DELAY_CYC),
		.expired_reg(pfc_exp)
	);

	// ****************************************
	// next phase decision
	// ****************************************
	always @*
	begin
		phase_next = phase_reg;
		load_phase = 1'b0;
		phase_load_val = 32'h00000000;
		load_pfc = 1'b0;
		case (phase_reg)
			`LBS_PH_UVLO:
			begin
				if (vcc_above_lockout)
					phase_next = `LBS_PH_HYST;
			end
			`LBS_PH_HYST:
			begin
				if (!vcc_above_lockout)
					phase_next = `LBS_PH_UVLO;
				else if (vcc_above_start && fil_ok)
				begin
					phase_next = `LBS_PH_BUSCHK;
					load_phase = 1'b1;
					phase_load_val = BUS_SAMPLE_CYC;
				end
			end
			`LBS_PH_BUSCHK:
			begin
				if (!vcc_above_lockout)
					phase_next = `LBS_PH_UVLO;
				else if (phase_exp && bus_in_band && fil_ok)
				begin
					phase_next = `LBS_PH_START;
					load_phase = 1'b1;
					phase_load_val = BUS95_CYC;
					load_pfc = 1'b1;
				end
				else if (phase_exp)
					phase_next = `LBS_PH_FAULT;
			end
			`LBS_PH_START:
			begin
				if (bus_above_95)
					phase_next = `LBS_PH_SOFT;
				else if (phase_exp)
					phase_next = `LBS_PH_FAULT;
			end
			`LBS_PH_SOFT:
			begin
				if (step_exp && freq_step_reg == SOFT_LAST[6:0])
				begin
					phase_next = `LBS_PH_PREHEAT;
					load_phase = 1'b1;
					phase_load_val = preheat_cyc;
				end
			end
			`LBS_PH_PREHEAT:
			begin
				if (phase_exp)
				begin
					phase_next = `LBS_PH_IGN;
					load_phase = 1'b1;
					phase_load_val = IGN_MAX_CYC;
				end
			end
			`LBS_PH_IGN:
			begin
				if (halted_reg && !low_side_current_sense)
				begin
					phase_next = `LBS_PH_PRERUN;
					load_phase = 1'b1;
					phase_load_val = PRERUN_CYC;
				end
				else if (phase_exp)
					phase_next = `LBS_PH_FAULT;
			end
			`LBS_PH_PRERUN:
			begin
				if (phase_exp)
					phase_next = `LBS_PH_RUN;
			end
			`LBS_PH_RUN:
			begin
				if (run_err)
					phase_next = `LBS_PH_FAULT;
			end
			`LBS_PH_FAULT:
			begin
				// only lockout releases the fault state
				if (!vcc_above_lockout)
					phase_next = `LBS_PH_UVLO;
			end
			default:
			begin
				phase_next = `LBS_PH_UVLO;
			end
		endcase
		// supply below lockout forces the block idle from any phase
		if (!vcc_above_lockout)
		begin
			phase_next = `LBS_PH_UVLO;
			load_phase = 1'b0;
			load_pfc = 1'b0;
		end
	end

	// ****************************************
	// step timer reload control
	// ****************************************
	always @*
	begin
		load_step = 1'b0;
		// one less: the registered expiry costs a cycle before the reload
		step_load_val = SOFT_STEP_CYC - 1;
		if (phase_reg == `LBS_PH_START && phase_next == `LBS_PH_SOFT)
			load_step = 1'b1;
		else if (phase_reg == `LBS_PH_SOFT && step_exp)
			load_step = 1'b1;
		else if (phase_reg == `LBS_PH_PREHEAT && phase_next == `LBS_PH_IGN)
		begin
			load_step = 1'b1;
			step_load_val = IGN_STEP_CYC - 1;
		end
		else if (phase_reg == `LBS_PH_IGN && step_exp && !halted_reg)
		begin
			load_step = 1'b1;
			step_load_val = IGN_STEP_CYC - 1;
		end
	end

	// ****************************************
	// phase register and frequency stepping
	// ****************************************
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_reg <= `LBS_PH_UVLO;
			freq_mode_reg <= FM_START;
			freq_step_reg <= 7'h00;
			halted_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			phase_reg <= phase_next;
			if (phase_next != phase_reg)
			begin
				freq_step_reg <= 7'h00;
				halted_reg <= 1'b0;
				case (phase_next)
					`LBS_PH_SOFT: freq_mode_reg <= FM_SOFT;
					`LBS_PH_PREHEAT: freq_mode_reg <= FM_PREHEAT;
					`LBS_PH_IGN, `LBS_PH_PRERUN, `LBS_PH_RUN: freq_mode_reg <= FM_IGN;
					default: freq_mode_reg <= FM_START;
				endcase
			end
			else if (phase_reg == `LBS_PH_SOFT && step_exp)
				freq_step_reg <= freq_step_reg + 7'h01;
			else if (phase_reg == `LBS_PH_IGN)
			begin
				// slope and level seen: stop descent, wait for ignition
				if (current_slope_hit && low_side_current_sense)
					halted_reg <= 1'b1;
				else if (step_exp && !halted_reg && freq_step_reg != IGN_LAST[6:0])
					freq_step_reg <= freq_step_reg + 7'h01;
			end
			else if (phase_reg == `LBS_PH_PRERUN || phase_reg == `LBS_PH_RUN)
				freq_step_reg <= IGN_LAST[6:0];
		end
	end

	// ****************************************
	// gate enables, detection and status
	// ****************************************
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			inv_gate_en_reg <= 1'b0;
			pfc_gate_en_reg <= 1'b0;
			detect_active_reg <= 1'b0;
			low_fil_open_reg <= 1'b0;
			high_fil_open_reg <= 1'b0;
			restart_boost_reg <= 1'b0;
			monitor_en_reg <= 1'b0;
			run_fault_reg <= 1'b0;
			latched_fault_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			// inverter gate active from fixed start through run
			inv_gate_en_reg <= (phase_next == `LBS_PH_START) || (phase_next == `LBS_PH_SOFT)
				|| (phase_next == `LBS_PH_PREHEAT) || (phase_next == `LBS_PH_IGN)
				|| (phase_next == `LBS_PH_PRERUN) || (phase_next == `LBS_PH_RUN);
			// pfc waits for its delay after inverter start
			pfc_gate_en_reg <= inv_gate_en_reg && pfc_exp && !load_pfc && (phase_next != `LBS_PH_FAULT)
				&& (phase_next != `LBS_PH_UVLO);
			// detection in hysteresis and bus check only
			detect_active_reg <= (phase_next == `LBS_PH_HYST) || (phase_next == `LBS_PH_BUSCHK);
			low_fil_open_reg <= (phase_reg == `LBS_PH_HYST) && restart_above_thr;
			high_fil_open_reg <= (phase_reg == `LBS_PH_HYST) && !lamp_sense_ok;
			restart_boost_reg <= (phase_reg == `LBS_PH_HYST) && !lamp_sense_ok;
			monitor_en_reg <= (phase_next == `LBS_PH_RUN);
			if (phase_next == `LBS_PH_UVLO)
				run_fault_reg <= 1'b0;
			else if (phase_reg == `LBS_PH_RUN && run_err)
				run_fault_reg <= 1'b1;
			latched_fault_reg <= (phase_next == `LBS_PH_FAULT);
		end
	end
endmodule // lbs_sequencer

// File: bench/lbs_chk.sv
// assertion checker for the ballast start-up sequencer
`timescale 1ns/1ps
module lbs_chk
(
	input wire clk_sys,
	input wire rst_n,
	input wire clk_en,
	input wire vcc_above_lockout,
	input wire restart_above_thr,
	input wire lamp_voltage_sense_a,
	input wire lamp_voltage_sense_b,
	input wire low_side_current_sense,
	input wire current_slope_hit,
	input wire [9:0] phase_reg,
	input wire [1:0] freq_mode_reg,
	input wire [6:0] freq_step_reg,
	input wire inv_gate_en_reg,
	input wire pfc_gate_en_reg,
	input wire monitor_en_reg,
	input wire latched_fault_reg
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ****************
	// phase rules
	// ****************
	AST_IDLE_GATES: assert property ((phase_reg[0] || phase_reg[9]) |-> !inv_gate_en_reg && !pfc_gate_en_reg)
		else $error("gates active in lockout or fault");
	AST_LOCKOUT: assert property (!vcc_above_lockout && clk_en |=> phase_reg == 10'h001)
		else $error("active with supply below lockout");
	AST_HYST_ENTRY: assert property (phase_reg == 10'h001 && vcc_above_lockout && clk_en |=> phase_reg == 10'h002)
		else $error("no detection after supply rise");
	AST_BUSCHK_HOLD: assert property ($rose(phase_reg == 10'h004) |-> (phase_reg == 10'h004)[*8])
		else $error("bus sampling window cut short");
	AST_START_FREQ: assert property (phase_reg == 10'h008 |-> inv_gate_en_reg && freq_mode_reg == 2'd0)
		else $error("start phase without fixed start frequency");
	AST_PFC_LAG: assert property ($rose(pfc_gate_en_reg) |-> $past(inv_gate_en_reg, 8))
		else $error("pfc gate ahead of inverter");
	AST_SOFT_END: assert property ($rose(phase_reg == 10'h020) |-> $past(freq_step_reg) == 7'd14)
		else $error("soft start left before last step");
	AST_IGN_HALT: assert property (phase_reg == 10'h040 && current_slope_hit && low_side_current_sense
		|=> ##1 (phase_reg != 10'h040 || $stable(freq_step_reg)))
		else $error("frequency still falling after slope hit");
	AST_RUN_ENTRY: assert property ($rose(phase_reg == 10'h100) |-> $past(phase_reg) == 10'h080 && monitor_en_reg)
		else $error("run entered without pre-run");
	AST_FAULT_HOLD: assert property (latched_fault_reg && vcc_above_lockout |=> latched_fault_reg)
		else $error("latched fault left with supply up");
	AST_FIL_BLOCK: assert property (phase_reg == 10'h002 && (restart_above_thr
		|| !(lamp_voltage_sense_a || lamp_voltage_sense_b)) |=> phase_reg != 10'h004)
		else $error("power-up with filament open");
endmodule // lbs_chk

bind lbs_sequencer lbs_chk u_chk (.clk_sys, .rst_n, .clk_en, .vcc_above_lockout, .restart_above_thr,
	.lamp_voltage_sense_a, .lamp_voltage_sense_b, .low_side_current_sense, .current_slope_hit, .phase_reg,
	.freq_mode_reg, .freq_step_reg, .inv_gate_en_reg, .pfc_gate_en_reg, .monitor_en_reg, .latched_fault_reg);

// File: bench/lbs_stage.sv
// power stage and lamp sensing network model
`timescale 1ns/1ps
module lbs_stage
#(
	parameter RISE = 40
)
(
	input wire clk_sys,
	input wire rst_n,
	input wire inv_gate_en_reg,
	input wire pfc_gate_en_reg,
	input wire [1:0] freq_mode_reg,
	input wire [6:0] freq_step_reg,
	input wire restart_boost_reg,
	input wire lo_ok,
	input wire hi_ok,
	input wire slow,
	input wire strikes,
	input wire [6:0] hit_step,
	output reg bus_above_95,
	output reg low_side_current_sense,
	output reg current_slope_hit,
	output reg restart_above_thr,
	output reg lamp_voltage_sense_a
);
	reg [15:0] cnt;
	reg [7:0] hold;
	reg lit;
	wire hit = inv_gate_en_reg && freq_mode_reg == 2'd3 && !lit && freq_step_reg >= hit_step;
	// bus charge-up, filament network and resonant ignition
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 16'h0;
			hold <= 8'h0;
			lit <= 1'b0;
			bus_above_95 <= 1'b0;
			low_side_current_sense <= 1'b0;
			current_slope_hit <= 1'b0;
			restart_above_thr <= 1'b0;
			lamp_voltage_sense_a <= 1'b0;
		end
		else
		begin
			cnt <= pfc_gate_en_reg ? cnt + 16'h1 : 16'h0;
			bus_above_95 <= pfc_gate_en_reg && !slow && cnt >= RISE;
			restart_above_thr <= !lo_ok || (!hi_ok && restart_boost_reg);
			lamp_voltage_sense_a <= hi_ok;
			hold <= hit ? hold + 8'h1 : 8'h0;
			lit <= inv_gate_en_reg && (lit || (strikes && hold >= 8'd10));
			low_side_current_sense <= hit;
			current_slope_hit <= hit;
		end
	end
endmodule // lbs_stage

// File: bench/testbench.sv
// self-checking bench for the ballast start-up sequencer
`timescale 1ns/1ps
module testbench;
	reg clk_sys = 1'b0;
	reg rst_n = 1'b0;
	reg vcc_lo = 1'b0;
	reg vcc_st = 1'b0;
	reg [1:0] band = 2'h0;
	reg [7:0] flt = 8'h00;
	reg [6:0] ph_set = 7'h00;
	reg lo_ok = 1'b1;
	reg hi_ok = 1'b1;
	reg slow = 1'b0;
	reg strikes = 1'b1;
	reg [6:0] hit_step = 7'h05;
	reg [31:0] seed = 32'h4a;
	reg en = 1'b1;
	reg sense_b = 1'b0;
	localparam int P_BUS95 = 200;
	localparam int P_PH_MAX = 127;
	localparam int P_IGN_MAX = 3000;
	localparam int P_PRERUN = 100;
	localparam int P_SAMPLE = 20;
	localparam int P_PFC = 30;
	localparam int P_SOFT = 20;
	localparam int P_IGN_STEP = 20;
	int fails = 0;
	int n_checks = 0;
	int k;
	logic [11:0] q[$];
	logic [11:0] last = 12'h004;
	wire [9:0] phase_reg;
	wire [1:0] freq_mode_reg;
	wire [6:0] freq_step_reg;
	wire inv_gate_en_reg, pfc_gate_en_reg, detect_active_reg, low_fil_open_reg, high_fil_open_reg;
	wire restart_boost_reg, monitor_en_reg, run_fault_reg, latched_fault_reg;
	wire bus_above_95, low_side_current_sense, current_slope_hit, restart_above_thr, lamp_voltage_sense_a;
	wire [11:0] obs = {phase_reg, inv_gate_en_reg, monitor_en_reg};
	lbs_sequencer #(.BUS95_CYC(P_BUS95), .PREHEAT_MAX_CYC(P_PH_MAX), .IGN_MAX_CYC(P_IGN_MAX), .PRERUN_CYC(P_PRERUN),
		.BUS_SAMPLE_CYC(P_SAMPLE), .PFC_DELAY_CYC(P_PFC), .SOFT_STEP_CYC(P_SOFT), .IGN_STEP_CYC(P_IGN_STEP)) i_dut (
		.clk_sys, .rst_n,
		.clk_en(en), .vcc_above_lockout(vcc_lo), .vcc_above_start(vcc_st), .bus_below_low(band[1]),
		.bus_above_high(band[0]), .bus_above_95, .restart_above_thr, .lamp_voltage_sense_a,
		.lamp_voltage_sense_b(sense_b), .low_side_current_sense, .current_slope_hit, .preheat_time_set(ph_set),
		.bus_overvoltage(flt[0]), .bus_undervoltage(flt[1]), .open_loop(flt[2]), .pfc_overcurrent(flt[3]),
		.inv_overcurrent(flt[4]), .lamp_overvoltage_fault(flt[5]), .rectifier_effect_fault(flt[6]),
		.capacitive_load(flt[7]), .phase_reg, .freq_mode_reg, .freq_step_reg, .inv_gate_en_reg, .pfc_gate_en_reg,
		.detect_active_reg, .low_fil_open_reg, .high_fil_open_reg, .restart_boost_reg, .monitor_en_reg,
		.run_fault_reg, .latched_fault_reg);
	lbs_stage u_stage (.clk_sys, .rst_n, .inv_gate_en_reg, .pfc_gate_en_reg, .freq_mode_reg, .freq_step_reg,
		.restart_boost_reg, .lo_ok, .hi_ok, .slow, .strikes, .hit_step, .bus_above_95, .low_side_current_sense,
		.current_slope_hit, .restart_above_thr, .lamp_voltage_sense_a);
	// ****************
	// helpers
	// ****************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_checks++;
		if (got !== want)
		begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, want);
		end
	endtask
	// note the expected state, then wait for the phase; n is cycles spent
	task automatic expect_ph(input logic [9:0] ph, output int n);
		q.push_back({ph, |(ph & 10'h1f8), ph[8]});
		n = 0;
		while (phase_reg !== ph && n < 4000)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 4000)
			chk(phase_reg, ph);
		@(posedge clk_sys);
	endtask
	task give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one start-up: i below 8 runs and trips fault i, 8 stalls the bus, 9 never ignites
	task automatic run_up(input int i);
		ph_set <= 7'(rnd());
		hit_step <= 7'(rnd() % 40 + 1);
		slow <= (i == 8);
		strikes <= (i != 9);
		vcc_lo <= 1'b1;
		vcc_st <= 1'b1;
		expect_ph(10'h002, k);
		expect_ph(10'h004, k);
		expect_ph(10'h008, k);
		chk(k >= P_SAMPLE && k <= P_SAMPLE + 2, 1'b1);
		chk(pfc_gate_en_reg, 1'b0);
		if (i == 8)
		begin
			expect_ph(10'h200, k);
			chk(k >= P_BUS95 - 1 && k <= P_BUS95 + 3, 1'b1);
		end
		else
		begin
			expect_ph(10'h010, k);
			chk(pfc_gate_en_reg, 1'b1);
			expect_ph(10'h020, k);
			chk(k >= 15 * P_SOFT - 1 && k <= 15 * P_SOFT + 3, 1'b1);
			expect_ph(10'h040, k);
			chk(k >= int'(ph_set) - 1 && k <= int'(ph_set) + 3, 1'b1);
			expect_ph(i == 9 ? 10'h200 : 10'h080, k);
			if (i == 9)
				chk(k >= P_IGN_MAX - 5 && k <= P_IGN_MAX + 5, 1'b1);
			else
			begin
				expect_ph(10'h100, k);
				chk(k >= P_PRERUN - 1 && k <= P_PRERUN + 3, 1'b1);
				flt <= 8'h01 << i;
				expect_ph(10'h200, k);
				chk(run_fault_reg, 1'b1);
			end
		end
		chk(latched_fault_reg, 1'b1);
		flt <= 8'h00;
		vcc_lo <= 1'b0;
		vcc_st <= 1'b0;
		expect_ph(10'h001, k);
	endtask
	// ****************
	// clock, checking and sequence
	// ****************
	initial
	begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// compare each change of phase and gate state with the oldest note
	always @(negedge clk_sys)
	begin
		if (rst_n && obs !== last)
		begin
			if (q.size() == 0)
				chk(obs, last);
			else
				chk(obs, q.pop_front());
			last = obs;
		end
	end
	initial
	begin
		#300000;
		fails++;
		give_verdict();
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		chk(obs, 12'h004);
		hi_ok <= 1'b0;
		vcc_lo <= 1'b1;
		expect_ph(10'h002, k);
		chk(detect_active_reg, 1'b1);
		vcc_st <= 1'b1;
		repeat (50) @(posedge clk_sys);
		chk({phase_reg, high_fil_open_reg, restart_boost_reg}, {10'h002, 2'b11});
		sense_b <= 1'b1;
		lo_ok <= 1'b0;
		repeat (50) @(posedge clk_sys);
		chk({phase_reg, low_fil_open_reg, high_fil_open_reg}, {10'h002, 2'b10});
		hi_ok <= 1'b1;
		lo_ok <= 1'b1;
		band <= rnd() % 2 ? 2'b01 : 2'b10;
		expect_ph(10'h004, k);
		expect_ph(10'h200, k);
		chk(k >= P_SAMPLE && k <= P_SAMPLE + 2, 1'b1);
		band <= 2'b00;
		sense_b <= 1'b0;
		repeat (30) @(posedge clk_sys);
		chk(phase_reg, 10'h200);
		en <= 1'b0;
		vcc_lo <= 1'b0;
		vcc_st <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk(phase_reg, 10'h200);
		en <= 1'b1;
		expect_ph(10'h001, k);
		for (int i = 0; i < 10; i++)
			run_up(i);
		give_verdict();
	end
endmodule // testbench
